// *** bench/bte_bus_model.sv ***
// observed processor bus driver with hit collector
`timescale 1ns/1ps
`default_nettype none
module bte_bus_model (
    input  wire logic        clk_i,
    input  wire logic [3:0]  term_hit_i,
    output logic             cyc_end_o,
    output logic [31:0]      word_o
);
    initial cyc_end_o = 1'b0;
    initial word_o = 32'h0000_0000;
    task automatic put(input logic [31:0] w, output logic [3:0] h);
        h = 4'h0;
        @(posedge clk_i);
        word_o <= w;
        @(posedge clk_i);
        cyc_end_o <= 1'b1;
        repeat (4) @(posedge clk_i) h = h | term_hit_i;
        // released pins show the inverse, not stale data
        word_o <= ~w;
        cyc_end_o <= 1'b0;
        repeat (6) @(posedge clk_i) h = h | term_hit_i;
    endtask : put
endmodule : bte_bus_model
`default_nettype wire

// *** bench/bte_top_bench.sv ***
// self-checking bench for the event term matcher
`timescale 1ns/1ps
`default_nettype none
module bte_top_bench;
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        req = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        cyc_end;
    logic [31:0] bw;
    logic [3:0]  term_hit_o;
    logic        halt_o;
    logic        irq_o;
    logic [31:0] rs = 32'h0001_7881;
    logic [31:0] pat [4];
    logic [31:0] care [4];
    logic [3:0]  fl [4];
    logic [31:0] q;
    logic [31:0] w;
    logic [3:0]  h;
    logic [3:0]  e;
    logic        arm;
    logic [4:0]  st;
    logic [4:0]  msk;
    logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20,
                            8'h14, 8'h60};
    logic [31:0] lay [5] = '{32'h0, 32'h40, 32'h400, 32'h4000, 32'h4040};
    int          err_total = 0;
    int          checks = 0;
    int          cyc_cnt = 0;
    always #2.5 clk_i = ~clk_i;
    bte_bus_model u_bus (.clk_i(clk_i), .term_hit_i(term_hit_o),
                         .cyc_end_o(cyc_end), .word_o(bw));
    bte_top dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cyc_end_i(cyc_end),
        .rw_i(bw[31]), .di_i(bw[30]), .probe_clip_three_i(bw[29]),
        .probe_clip_two_i(bw[28]), .probe_clip_one_i(bw[27]),
        .addr_i(bw[26:8]), .data_i(bw[7:0]), .term_hit_o(term_hit_o),
        .halt_o(halt_o), .irq_o(irq_o));
    function automatic logic [31:0] rnd();
        rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
        return rs;
    endfunction : rnd
    function automatic logic [3:0] ehit(input logic [31:0] x);
        logic m;
        ehit = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            if (fl[i][2] && i > 0)
                m = x >= (pat[i-1] & care[i-1]) && x <= (pat[i] | ~care[i]);
            else
                m = ((x ^ pat[i]) & care[i]) == 32'h0;
            ehit[i] = arm && fl[i][0] && !(i < 3 && fl[i+1][2]) && (m ^ fl[i][3]);
        end
    endfunction : ehit
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x)
        begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic wb(input logic r, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] o);
        @(posedge clk_i);
        req <= 1'b1;
        we <= r;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        o = wb_dat_o;
        req <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    always @(posedge clk_i)
    begin
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        foreach (ra[i])
        begin
            wb(0, ra[i], 0, q);
            chk(q, bte_pkg::RST_WORD);
        end
        for (int k = 0; k < 6; k++)
        begin
            wb(1, bte_pkg::REG_CTRL, 0, q);
            arm = 0;
            for (int i = 0; i < 4; i++)
            begin
                pat[i] = rnd();
                care[i] = rnd() | rnd();
                wb(1, 8'(8'h20 + 8 * i), pat[i], q);
                wb(1, 8'(8'h24 + 8 * i), care[i], q);
            end
            w = (rnd() & 32'h9999) | 32'h0115 | lay[k % 5];
            wb(1, bte_pkg::REG_FLAGS, w, q);
            for (int i = 0; i < 4; i++)
                fl[i] = w[4*i +: 4];
            fl[0][2] = 1'b0;
            wb(0, bte_pkg::REG_FLAGS, 0, q);
            chk(q[15:0], {fl[3], fl[2], fl[1], fl[0]});
            msk = 5'(rnd());
            wb(1, bte_pkg::REG_MASK, {27'h0, msk}, q);
            wb(1, bte_pkg::REG_STAT, 32'h1F, q);
            st = 0;
            arm = (k != 0);
            wb(1, bte_pkg::REG_CTRL, {31'h0, arm}, q);
            w = rnd();
            wb(1, 8'h20, w, q);
            if (!arm)
                pat[0] = w;
            for (int j = 0; j < 10; j++)
            begin
                w = rnd();
                if (w[0])
                    w = pat[j % 4] ^ (w & ~care[j % 4]);
                u_bus.put(w, h);
                e = ehit(w);
                chk(h, e);
                st = st | {1'b0, e};
                wb(0, bte_pkg::REG_SAMPLE, 0, q);
                chk(q, w);
            end
            wb(0, bte_pkg::REG_STAT, 0, q);
            chk(q, {27'h0, st});
            chk(irq_o, |(st & msk));
            chk(halt_o, 1'b0);
            wb(1, bte_pkg::REG_STAT, 32'h1F, q);
            repeat (2) @(posedge clk_i);
            chk(irq_o, 1'b0);
        end
        wb(1, bte_pkg::REG_CTRL, 0, q);
        wb(1, 8'h24, 0, q);
        wb(1, bte_pkg::REG_FLAGS, 32'h3, q);
        wb(1, bte_pkg::REG_CTRL, 32'h1, q);
        u_bus.put(32'h4000_0000, h);
        chk(halt_o, 1'b0);
        u_bus.put(32'h0, h);
        chk(halt_o, 1'b1);
        wb(0, bte_pkg::REG_STAT, 0, q);
        chk(q[4], 1'b1);
        wb(1, bte_pkg::REG_CTRL, 32'h3, q);
        chk(halt_o, 1'b0);
        tally_and_finish();
    end
endmodule : bte_top_bench
`default_nettype wire

// *** bench/bte_top_props.sv ***
// port checker for the event term matcher
`timescale 1ns/1ps
`default_nettype none
module bte_top_props (
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        cyc_end_i,
    input wire logic [3:0]  term_hit_o,
    input wire logic        halt_o,
    input wire logic        irq_o
);
    logic       ce_r;
    logic [3:0] since_r;
    logic       arm_r;
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire ctl = take && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0];
    // cycles since raw strobe edge, saturating
    always_ff @(posedge clk_i or negedge nrst_i)
        if (!nrst_i)
            since_r <= 4'hF;
        else if (cyc_end_i && !ce_r)
            since_r <= 4'h0;
        else if (since_r != 4'hF)
            since_r <= since_r + 4'h1;
    always_ff @(posedge clk_i or negedge nrst_i)
        if (!nrst_i)
            ce_r <= 1'b0;
        else
            ce_r <= cyc_end_i;
    always_ff @(posedge clk_i or negedge nrst_i)
        if (!nrst_i)
            arm_r <= 1'b0;
        else if (ctl)
            arm_r <= wb_dat_i[0];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    property p_hit_pulse;
        term_hit_o != 4'h0 |=> term_hit_o == 4'h0;
    endproperty
    a_hit_pulse: assert property (p_hit_pulse)
        else $error("hit held past one cycle");
    property p_hit_cause;
        term_hit_o != 4'h0 |-> since_r inside {[2:8]};
    endproperty
    a_hit_cause: assert property (p_hit_cause)
        else $error("hit without a sample");
    property p_noarm;
        !arm_r && !$past(arm_r) && !$past(arm_r, 2) |-> term_hit_o == 4'h0;
    endproperty
    a_noarm: assert property (p_noarm)
        else $error("hit while disarmed");
    property p_halt_hold;
        halt_o && !(ctl && wb_dat_i[1]) |=> halt_o;
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("halt dropped without resume");
    property p_halt_cause;
        $rose(halt_o) |-> since_r inside {[2:9]};
    endproperty
    a_halt_cause: assert property (p_halt_cause)
        else $error("halt not after a sample");
    property p_flag0;
        take && !wb_we_i && wb_adr_i == 8'h0C |=> wb_dat_o[2] == 1'b0;
    endproperty
    a_flag0: assert property (p_flag0)
        else $error("first term shows range flag");
    property p_ack;
        take |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus answer not one cycle");
    property p_high_adr;
        take && !wb_we_i && wb_adr_i > 8'h3F |=> wb_dat_o == 32'h0;
    endproperty
    a_high_adr: assert property (p_high_adr)
        else $error("read beyond four terms not zero");
    c_hit: cover property (term_hit_o != 4'h0);
    c_halt: cover property ($rose(halt_o));
    c_irq: cover property ($rose(irq_o));
endmodule : bte_top_props
bind bte_top bte_top_props u_props (.*);
`default_nettype wire

// *** verilog/bte_pkg.sv ***
// constants for the bus event term matcher
package bte_pkg;
    localparam int           NTERM      = 4;
    localparam int           WORD_W     = 32;
    localparam int           ADDR_W     = 19;
    localparam int           DATA_W     = 8;
    localparam int           CLIP_W     = 3;
    // state word layout
    localparam int           POS_RW     = 31;
    localparam int           POS_DI     = 30;
    localparam int           POS_CLIP   = 27;
    localparam int           POS_ADDR   = 8;
    localparam int           POS_DATA   = 0;
    // register byte offsets
    localparam logic [7:0]   REG_CTRL   = 8'h00;
    localparam logic [7:0]   REG_STAT   = 8'h04;
    localparam logic [7:0]   REG_MASK   = 8'h08;
    localparam logic [7:0]   REG_FLAGS  = 8'h0C;
    localparam logic [7:0]   REG_SAMPLE = 8'h10;
    localparam logic [2:0]   TERM_AREA  = 3'h1;
    // control bits
    localparam int           CTRL_ARM    = 0;
    localparam int           CTRL_RESUME = 1;
    // status layout: bits 3:0 term hits, bit 4 halt
    localparam int           STAT_W     = 5;
    localparam int           STAT_HALT  = 4;
    // per-term flag nibble
    localparam int           FLG_EN     = 0;
    localparam int           FLG_BRK    = 1;
    localparam int           FLG_RNG    = 2;
    localparam int           FLG_NEG    = 3;
    // values after reset
    localparam logic [31:0]  RST_WORD   = 32'h0000_0000;
    localparam logic [15:0]  RST_FLAGS  = 16'h0000;
    localparam logic [4:0]   RST_STAT   = 5'h00;
endpackage : bte_pkg

// *** verilog/bte_term_cmp.sv ***
// term comparator: masked equality and ranges
`timescale 1ns/1ps
`default_nettype none
module bte_term_cmp (
    bte_term_if.cmp t
);
    function automatic logic care_eq(input logic [31:0] w,
                                     input logic [31:0] p,
                                     input logic [31:0] c);
        care_eq = ((w ^ p) & c) == 32'h0000_0000;
    endfunction : care_eq

    logic [3:0]  lone;
    logic [3:0]  in_rng;
    logic [3:0]  low_end;
    logic [31:0] lo_b [bte_pkg::NTERM];
    logic [31:0] hi_b [bte_pkg::NTERM];

    always_comb
    begin
        for (int i = 0; i < bte_pkg::NTERM; i++)
        begin
            // R07: masked bits always match
            lone[i] = care_eq(t.word, t.pat[i], t.care[i]);
            // R16: don't-care low for lower, high for upper
            lo_b[i] = t.pat[i] & t.care[i];
            hi_b[i] = t.pat[i] | ~t.care[i];
        end
        in_rng[0]  = 1'b0;
        low_end[3] = 1'b0;
        for (int i = 1; i < bte_pkg::NTERM; i++)
        begin
            // R12: whole word, inclusive bounds
            in_rng[i] = (t.word >= lo_b[i-1]) && (t.word <= hi_b[i]);
            // R09: preceding term is lower end
            low_end[i-1] = t.range_end_flag[i];
        end
        for (int i = 0; i < bte_pkg::NTERM; i++)
        begin
            // R03 R05 R13: enable, negate, range result
            t.hit[i] = t.en[i] & ~low_end[i]
                     & ((t.range_end_flag[i] ? in_rng[i] : lone[i]) ^ t.neg[i]);
        end
    end
endmodule : bte_term_cmp
`default_nettype wire

// *** verilog/bte_term_if.sv ***
// carrier between term registers and comparator
`timescale 1ns/1ps
`default_nettype none
interface bte_term_if;
    logic [31:0] word;
    logic [31:0] pat  [bte_pkg::NTERM];
    logic [31:0] care [bte_pkg::NTERM];
    logic [3:0]  en;
    logic [3:0]  range_end_flag;
    logic [3:0]  neg;
    logic [3:0]  hit;
    modport cmp (input word, pat, care, en, range_end_flag, neg, output hit);
    modport ctl (output word, pat, care, en, range_end_flag, neg, input hit);
endinterface : bte_term_if
`default_nettype wire

// *** verilog/bte_top.sv ***
// bus event term matcher with wishbone registers
//
// Summary of operation
// R01: four terms, each a 32-bit pattern
// R02: read/write in MSB, lowest data bit LSB
// R03: disabled terms never match
// R04: breakpoint flag makes a match halt
// R05: negation flag inverts the match
// R06: read/write and data/instruction compare 0/1/X
// R07: address and clip bits compare 0/1/X
// R08: data bits 0/1/X, nibble X masks four
// R09: range flag marks upper end, previous is lower
// R10: first term has no range flag
// R11: four range layouts including two at once
// R12: range compares whole word, not address
// R13: range matches every word between the ends
// R14: sample bus once per processor cycle end
// R15: halt after the matching instruction completes
// R16: inclusive range, don't-care low/high bounds
// R17: term setup only while disarmed
`timescale 1ns/1ps
`default_nettype none
module bte_top (
    input  wire logic                      clk_i,
    input  wire logic                      nrst_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [7:0]                wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    input  wire logic                      cyc_end_i,
    input  wire logic                      rw_i,
    input  wire logic                      di_i,
    input  wire logic                      probe_clip_one_i,
    input  wire logic                      probe_clip_two_i,
    input  wire logic                      probe_clip_three_i,
    input  wire logic [bte_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [bte_pkg::DATA_W-1:0] data_i,
    output logic      [3:0]                term_hit_o,
    output logic                           halt_o,
    output logic                           irq_o
);
    localparam int PIN_W = 33;

    function automatic logic [31:0] sel_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  sel);
        for (int b = 0; b < 4; b++)
            sel_merge[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
    endfunction : sel_merge

    logic             rs1_r;
    logic             rs2_r;
    logic             rst_n;
    logic [PIN_W-1:0] pin1_r;
    logic [PIN_W-1:0] pin2_r;
    logic             cyc_d_r;
    logic             sample;
    logic             sample_d_r;
    logic [31:0]      word_r;
    logic             arm_r;
    logic [31:0]      pat_r  [bte_pkg::NTERM];
    logic [31:0]      care_r [bte_pkg::NTERM];
    logic [15:0]      flags_r;
    logic [31:0]      flags_mrg;
    logic [15:0]      flags_nxt;
    logic [bte_pkg::STAT_W-1:0] stat_r;
    logic [bte_pkg::STAT_W-1:0] mask_r;
    logic [bte_pkg::STAT_W-1:0] stat_set;
    logic             brk_pend_r;
    logic             halt_r;
    logic             halt_set;
    logic [3:0]       hit_r;
    logic             irq_r;
    logic             ack_r;
    logic [31:0]      dat_r;
    logic [31:0]      rd_nxt;
    logic             acc;
    logic             wr;
    logic [31:0]      wr_ctrl;
    logic             term_wr;
    logic [3:0]       live_hit;
    logic [3:0]       brk_bits;

    bte_term_if t ();

    bte_term_cmp u_cmp (
        .t (t.cmp)
    );

    // reset release through two flops
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rs1_r <= 1'b0;
            rs2_r <= 1'b0;
        end
        else
        begin
            rs1_r <= 1'b1;
            rs2_r <= rs1_r;
        end
    end
    assign rst_n = rs2_r;

    // pins come from the emulated cpu clock, two flops first
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin1_r <= '0;
            pin2_r <= '0;
        end
        else
        begin
            pin1_r <= {cyc_end_i, rw_i, di_i, probe_clip_three_i,
                       probe_clip_two_i, probe_clip_one_i, addr_i, data_i};
            pin2_r <= pin1_r;
        end
    end

    // R14: one sample per cycle-end rising edge
    assign sample = pin2_r[32] & ~cyc_d_r;

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cyc_d_r    <= 1'b0;
            sample_d_r <= 1'b0;
            word_r     <= bte_pkg::RST_WORD;
        end
        else
        begin
            cyc_d_r    <= pin2_r[32];
            sample_d_r <= sample;
            // R02 R06: rw at msb, di next, data at lsb
            if (sample)
                word_r <= pin2_r[31:0];
        end
    end

    // hold whole request until ack; one access per cycle-pair
    assign acc     = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr      = acc & wb_we_i;
    assign wr_ctrl = sel_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
    // R17: term setup frozen while armed
    assign term_wr = wr & ~arm_r & (wb_adr_i[7:5] == bte_pkg::TERM_AREA);

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < bte_pkg::NTERM; i++)
            begin
                pat_r[i]  <= bte_pkg::RST_WORD;
                care_r[i] <= bte_pkg::RST_WORD;
            end
        end
        else if (term_wr)
        begin
            // R01 R08: per-bit care mask, nibble X clears four bits
            if (wb_adr_i[2])
                care_r[wb_adr_i[4:3]] <= sel_merge(care_r[wb_adr_i[4:3]],
                                                   wb_dat_i, wb_sel_i);
            else
                pat_r[wb_adr_i[4:3]] <= sel_merge(pat_r[wb_adr_i[4:3]],
                                                  wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags_r <= bte_pkg::RST_FLAGS;
            arm_r   <= 1'b0;
            mask_r  <= bte_pkg::RST_STAT;
        end
        else if (wr)
        begin
            if (wb_adr_i == bte_pkg::REG_CTRL && wb_sel_i[0])
                arm_r <= wb_dat_i[bte_pkg::CTRL_ARM];
            else if (wb_adr_i == bte_pkg::REG_MASK && wb_sel_i[0])
                mask_r <= wb_dat_i[bte_pkg::STAT_W-1:0];
            else if (wb_adr_i == bte_pkg::REG_FLAGS && !arm_r)
                flags_r <= flags_nxt;
        end
    end

    // R10: first term range flag held at zero
    always_comb
    begin
        flags_mrg = sel_merge({16'h0000, flags_r}, wb_dat_i, wb_sel_i);
        flags_nxt = flags_mrg[15:0];
        flags_nxt[bte_pkg::FLG_RNG] = 1'b0;
    end

    // R11: flags nibbles give each range layout
    always_comb
    begin
        for (int i = 0; i < bte_pkg::NTERM; i++)
        begin
            t.en[i]     = flags_r[4*i + bte_pkg::FLG_EN];
            t.range_end_flag[i]    = flags_r[4*i + bte_pkg::FLG_RNG];
            t.neg[i]    = flags_r[4*i + bte_pkg::FLG_NEG];
            brk_bits[i] = flags_r[4*i + bte_pkg::FLG_BRK];
            t.pat[i]    = pat_r[i];
            t.care[i]   = care_r[i];
        end
        t.word = word_r;
    end

    // evaluate the word captured on the previous edge
    assign live_hit = (sample_d_r & arm_r) ? t.hit : 4'h0;

    // R15: halt at the next opcode fetch after the hit
    // disarmed analyzer never halts, even with a hit pending
    assign halt_set = brk_pend_r & sample_d_r & arm_r
                    & ~word_r[bte_pkg::POS_DI];

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            brk_pend_r <= 1'b0;
            halt_r     <= 1'b0;
        end
        else
        begin
            // R04: only breakpoint terms arm the halt
            if (|(live_hit & brk_bits))
                brk_pend_r <= 1'b1;
            else if (halt_set)
                brk_pend_r <= 1'b0;
            // new halt wins over a resume in the same cycle
            if (halt_set)
                halt_r <= 1'b1;
            else if (wr && wb_adr_i == bte_pkg::REG_CTRL
                     && wr_ctrl[bte_pkg::CTRL_RESUME])
                halt_r <= 1'b0;
        end
    end

    assign stat_set = {halt_set, live_hit};

    // sticky status, write one to clear, set wins
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            stat_r <= bte_pkg::RST_STAT;
        else if (wr && wb_adr_i == bte_pkg::REG_STAT)
            stat_r <= (stat_r & ~wr_ctrl[bte_pkg::STAT_W-1:0]) | stat_set;
        else
            stat_r <= stat_r | stat_set;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hit_r <= 4'h0;
            irq_r <= 1'b0;
        end
        else
        begin
            hit_r <= live_hit;
            irq_r <= |(stat_r & mask_r);
        end
    end

    // read decode; unmapped reads zero
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        if (wb_adr_i == bte_pkg::REG_CTRL)
            rd_nxt[bte_pkg::CTRL_ARM] = arm_r;
        else if (wb_adr_i == bte_pkg::REG_STAT)
            rd_nxt[bte_pkg::STAT_W-1:0] = stat_r;
        else if (wb_adr_i == bte_pkg::REG_MASK)
            rd_nxt[bte_pkg::STAT_W-1:0] = mask_r;
        else if (wb_adr_i == bte_pkg::REG_FLAGS)
            rd_nxt[15:0] = flags_r;
        else if (wb_adr_i == bte_pkg::REG_SAMPLE)
            rd_nxt = word_r;
        else if (wb_adr_i[7:5] == bte_pkg::TERM_AREA)
            rd_nxt = wb_adr_i[2] ? care_r[wb_adr_i[4:3]]
                                 : pat_r[wb_adr_i[4:3]];
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= acc;
            if (acc)
                dat_r <= rd_nxt;
        end
    end

    assign wb_ack_o   = ack_r;
    assign wb_dat_o   = dat_r;
    assign term_hit_o = hit_r;
    assign halt_o     = halt_r;
    assign irq_o      = irq_r;
endmodule : bte_top
`default_nettype wire
